// ---- verilog/mhf_pkg.sv ----
package mhf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_FILT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FILT_STAT  = 8'h04;
  localparam logic [7:0] OFS_HASH_UPPER = 8'h08;
  localparam logic [7:0] OFS_HASH_LOWER = 8'h0C;
  localparam logic [7:0] OFS_MGMT_CMD   = 8'h10;
  localparam logic [7:0] OFS_MGMT_DATA  = 8'h14;

  // Field positions
  localparam int CTRL_HASH_BIT  = 2;
  localparam int CTRL_ALLM_BIT  = 4;
  localparam int CMD_BUSY_BIT   = 0;
  localparam int CMD_WSEL_BIT   = 1;
  localparam int CMD_DIV_LSB    = 2;
  localparam int CMD_RA_LSB     = 6;
  localparam int CMD_PHY_LSB    = 11;
  localparam int STAT_HIT_BIT   = 8;
  localparam int STAT_PASS_BIT  = 9;

  // Values after reset
  localparam logic [31:0] HASH_RST  = 32'h0000_0000;
  localparam logic [4:0]  ADDR_RST  = 5'h00;
  localparam logic [3:0]  DIV_RST   = 4'h0;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  // CRC parameters
  localparam logic [31:0] CRC_POLY  = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
  localparam logic [2:0]  DA_BYTES  = 3'h6;

  // MDC half periods in system clocks, one per divider code
  localparam logic [6:0] HALF_DIV42  = 7'h15;
  localparam logic [6:0] HALF_DIV62  = 7'h1F;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV26  = 7'h0D;
  localparam logic [6:0] HALF_DIV102 = 7'h33;
  localparam logic [6:0] HALF_DIV122 = 7'h3D;

  // Management frame layout
  localparam logic [31:0] MF_PREAMBLE  = 32'hFFFF_FFFF;
  localparam logic [1:0]  MF_START     = 2'h1;
  localparam logic [1:0]  MF_OP_READ   = 2'h2;
  localparam logic [1:0]  MF_OP_WRITE  = 2'h1;
  localparam logic [1:0]  MF_TA_WRITE  = 2'h2;
  localparam logic [1:0]  MF_TA_READ   = 2'h3;
  localparam logic [6:0]  MF_TA_FIRST  = 7'h2E;
  localparam logic [6:0]  MF_DATA_FIRST = 7'h30;
  localparam logic [6:0]  MF_LAST_BIT  = 7'h3F;

  typedef enum logic [1:0] {MHF_IDLE, MHF_SHIFT, MHF_LOAD, MHF_FREE} mhf_mstate_t;

endpackage : mhf_pkg

// ---- verilog/mhf_crc32.sv ----
`timescale 1ns/1ps
module mhf_crc32 (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_ff
);

  logic [31:0] nxt_crc;

  // One byte per cycle, least significant bit first, from all ones on init
  always_comb begin
    logic [31:0] c;
    c = init ? mhf_pkg::CRC_INIT : crc_ff;
    for (int i = 0; i < 8; i++) begin
      c = (c[31] ^ data[i]) ? ({c[30:0], 1'b0} ^ mhf_pkg::CRC_POLY) : {c[30:0], 1'b0};
    end
    nxt_crc = c;
  end

  // Remainder register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ff <= mhf_pkg::CRC_INIT;
    end else if (en) begin
      crc_ff <= nxt_crc;
    end
  end

endmodule : mhf_crc32

// ---- verilog/mhf_mdc_div.sv ----
`timescale 1ns/1ps
module mhf_mdc_div (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [6:0] half_cnt,
  output logic            tick_ff
);

  logic [6:0] cnt_ff;

  // Pulse once per MDC half period while a frame runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff == half_cnt - 7'h01) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 7'h01;
      tick_ff <= 1'b0;
    end
  end

endmodule : mhf_mdc_div

// ---- verilog/mhf_top.sv ----
// Overview of operation
// - Sixty-four bit hash table held in upper and lower software registers.
// - CRC over destination address; index is six inverted top CRC bits.
// - Index top bit picks upper or lower word; low five pick bit.
// - Selected table bit one accepts a multicast frame, zero rejects it.
// - Pass-all-multicast accepts every multicast frame regardless of the table.
// - CRC uses standard polynomial, all-ones start, complemented final value.
// - Five-bit command field selects one of 32 PHY devices.
// - Five-bit command field selects the register inside the PHY.
// - Four-bit range code sets MDC divider: 42, 62, 16, 26, 102, 122.
// - Write-select one writes data register to PHY, zero reads it.
// - Software sets busy to launch; hardware holds it, clears when done.
// - Data register contents are invalid while a read is running.
// - Data register holds write data and receives read-back data.
// - Hash-multicast set filters multicast by hash, else by perfect match.
// - Management data is sixteen bits in the data register low half.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module mhf_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  input  wire logic        rx_da_valid,
  input  wire logic        rx_da_first,
  input  wire logic [7:0]  rx_da_byte,
  input  wire logic        rx_perfect_match,
  output logic             filt_valid_ff,
  output logic             filt_pass_ff,
  output logic             filt_hash_hit_ff,
  output logic             mdc_ff,
  input  wire logic        mdio_in,
  output logic             mdio_out_ff,
  output logic             mdio_oe_n_ff
);

  // Software state
  logic [31:0] hash_bits_upper_ff;
  logic [31:0] hash_bits_lower_ff;
  logic        pass_all_multicast_ff;
  logic        hash_multicast_enable_ff;
  logic [4:0]  phy_select_ff;
  logic [4:0]  phy_register_select_ff;
  logic [3:0]  mdc_divider_range_ff;
  logic        mgmt_write_select_ff;
  logic        mgmt_busy_flag_ff;
  logic [15:0] mgmt_data_field_ff;

  // Filter state
  logic [2:0]  da_cnt_ff;
  logic        da_mcast_ff;
  logic        da_eval_ff;
  logic [5:0]  last_index_ff;
  logic [31:0] crc_raw;
  logic [31:0] crc_final;
  logic [5:0]  hash_index;
  logic        hash_bit;
  logic        da_take;

  // Management engine state
  mhf_pkg::mhf_mstate_t state_ff;
  logic [6:0]  bit_cnt_ff;
  logic [63:0] tx_shift_ff;
  logic [15:0] rd_shift_ff;
  logic        mdio_meta_ff;
  logic        mdio_sync_ff;
  logic        mdc_tick;
  logic [6:0]  half_cnt;
  logic [63:0] frame;
  logic [6:0]  nxt_bit_cnt;
  logic        mgmt_start;

  // Bus decode
  logic        acc_phase;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] rd_word;

  assign acc_phase = psel & penable;
  assign wr_en     = acc_phase & pwrite & pready_ff;

  // Read multiplexer; unused command and data bits read zero
  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      mhf_pkg::OFS_FILT_CTRL: begin
        rd_word[mhf_pkg::CTRL_ALLM_BIT] = pass_all_multicast_ff;
        rd_word[mhf_pkg::CTRL_HASH_BIT] = hash_multicast_enable_ff;
      end
      mhf_pkg::OFS_FILT_STAT: begin
        rd_word[5:0]                    = last_index_ff;
        rd_word[mhf_pkg::STAT_HIT_BIT]  = filt_hash_hit_ff;
        rd_word[mhf_pkg::STAT_PASS_BIT] = filt_pass_ff;
      end
      mhf_pkg::OFS_HASH_UPPER: rd_word = hash_bits_upper_ff;
      mhf_pkg::OFS_HASH_LOWER: rd_word = hash_bits_lower_ff;
      mhf_pkg::OFS_MGMT_CMD: begin
        rd_word[mhf_pkg::CMD_PHY_LSB +: 5] = phy_select_ff;
        rd_word[mhf_pkg::CMD_RA_LSB +: 5]  = phy_register_select_ff;
        rd_word[mhf_pkg::CMD_DIV_LSB +: 4] = mdc_divider_range_ff;
        rd_word[mhf_pkg::CMD_WSEL_BIT]     = mgmt_write_select_ff;
        rd_word[mhf_pkg::CMD_BUSY_BIT]     = mgmt_busy_flag_ff;
      end
      mhf_pkg::OFS_MGMT_DATA: rd_word[15:0] = mgmt_data_field_ff;
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: one wait state, read data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc_phase & ~pready_ff;
      pslverr_ff <= acc_phase & ~pready_ff & ~addr_ok;
      if (acc_phase & ~pready_ff & ~pwrite) begin
        prdata_ff <= addr_ok ? rd_word : 32'h0000_0000;
      end
    end
  end

  // Hash table words, full-word writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hash_bits_upper_ff <= mhf_pkg::HASH_RST;
      hash_bits_lower_ff <= mhf_pkg::HASH_RST;
    end else if (wr_en) begin
      if (paddr == mhf_pkg::OFS_HASH_UPPER) begin
        hash_bits_upper_ff <= pwdata;
      end
      if (paddr == mhf_pkg::OFS_HASH_LOWER) begin
        hash_bits_lower_ff <= pwdata;
      end
    end
  end

  // Filter controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_all_multicast_ff    <= 1'b0;
      hash_multicast_enable_ff <= 1'b0;
    end else if (wr_en && paddr == mhf_pkg::OFS_FILT_CTRL) begin
      pass_all_multicast_ff    <= pwdata[mhf_pkg::CTRL_ALLM_BIT];
      hash_multicast_enable_ff <= pwdata[mhf_pkg::CTRL_HASH_BIT];
    end
  end

  // Command register; a write with busy set launches an access when idle
  assign mgmt_start = wr_en && paddr == mhf_pkg::OFS_MGMT_CMD
                      && pwdata[mhf_pkg::CMD_BUSY_BIT] && !mgmt_busy_flag_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_select_ff          <= mhf_pkg::ADDR_RST;
      phy_register_select_ff <= mhf_pkg::ADDR_RST;
      mdc_divider_range_ff   <= mhf_pkg::DIV_RST;
      mgmt_write_select_ff   <= 1'b0;
    end else if (wr_en && paddr == mhf_pkg::OFS_MGMT_CMD && !mgmt_busy_flag_ff) begin
      phy_select_ff          <= pwdata[mhf_pkg::CMD_PHY_LSB +: 5];
      phy_register_select_ff <= pwdata[mhf_pkg::CMD_RA_LSB +: 5];
      mdc_divider_range_ff   <= pwdata[mhf_pkg::CMD_DIV_LSB +: 4];
      mgmt_write_select_ff   <= pwdata[mhf_pkg::CMD_WSEL_BIT];
    end
  end

  // Busy: set by software launch, cleared by the engine once done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_busy_flag_ff <= 1'b0;
    end else if (mgmt_start) begin
      mgmt_busy_flag_ff <= 1'b1;
    end else if (state_ff == mhf_pkg::MHF_FREE) begin
      mgmt_busy_flag_ff <= 1'b0;
    end
  end

  // Data register: software value when idle, PHY value after a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_data_field_ff <= mhf_pkg::DATA_RST;
    end else if (state_ff == mhf_pkg::MHF_LOAD && !mgmt_write_select_ff) begin
      mgmt_data_field_ff <= rd_shift_ff;
    end else if (wr_en && paddr == mhf_pkg::OFS_MGMT_DATA && !mgmt_busy_flag_ff) begin
      mgmt_data_field_ff <= pwdata[15:0];
    end
  end

  // Divider code to half period; reserved codes fall back to the slowest
  always_comb begin
    unique case (mdc_divider_range_ff)
      4'h0:    half_cnt = mhf_pkg::HALF_DIV42;
      4'h1:    half_cnt = mhf_pkg::HALF_DIV62;
      4'h2:    half_cnt = mhf_pkg::HALF_DIV16;
      4'h3:    half_cnt = mhf_pkg::HALF_DIV26;
      4'h4:    half_cnt = mhf_pkg::HALF_DIV102;
      4'h5:    half_cnt = mhf_pkg::HALF_DIV122;
      default: half_cnt = mhf_pkg::HALF_DIV122;
    endcase
  end

  mhf_mdc_div u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (state_ff == mhf_pkg::MHF_SHIFT),
    .half_cnt (half_cnt),
    .tick_ff  (mdc_tick)
  );

  // Clause-22 frame: preamble, start, opcode, PHY, register, turnaround, data
  always_comb begin
    frame = {mhf_pkg::MF_PREAMBLE, mhf_pkg::MF_START,
             mgmt_write_select_ff ? mhf_pkg::MF_OP_WRITE : mhf_pkg::MF_OP_READ,
             phy_select_ff, phy_register_select_ff,
             mgmt_write_select_ff ? mhf_pkg::MF_TA_WRITE : mhf_pkg::MF_TA_READ,
             mgmt_data_field_ff};
  end

  assign nxt_bit_cnt = bit_cnt_ff + 7'h01;

  // Management data input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_meta_ff <= 1'b1;
      mdio_sync_ff <= 1'b1;
    end else begin
      mdio_meta_ff <= mdio_in;
      mdio_sync_ff <= mdio_meta_ff;
    end
  end

  // Frame engine: drive after MDC falls, sample just before MDC rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= mhf_pkg::MHF_IDLE;
      bit_cnt_ff   <= 7'h00;
      tx_shift_ff  <= 64'h0000_0000_0000_0000;
      rd_shift_ff  <= 16'h0000;
      mdc_ff       <= 1'b0;
      mdio_out_ff  <= 1'b1;
      mdio_oe_n_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        mhf_pkg::MHF_IDLE: begin
          if (mgmt_start) begin
            // Fields latch this same edge, so build the frame from the bus word
            tx_shift_ff  <= {mhf_pkg::MF_PREAMBLE, mhf_pkg::MF_START,
                             pwdata[mhf_pkg::CMD_WSEL_BIT] ? mhf_pkg::MF_OP_WRITE
                                                           : mhf_pkg::MF_OP_READ,
                             pwdata[mhf_pkg::CMD_PHY_LSB +: 5],
                             pwdata[mhf_pkg::CMD_RA_LSB +: 5],
                             pwdata[mhf_pkg::CMD_WSEL_BIT] ? mhf_pkg::MF_TA_WRITE
                                                           : mhf_pkg::MF_TA_READ,
                             mgmt_data_field_ff};
            bit_cnt_ff   <= 7'h00;
            mdc_ff       <= 1'b0;
            mdio_out_ff  <= frame[63];
            mdio_oe_n_ff <= 1'b0;
            state_ff     <= mhf_pkg::MHF_SHIFT;
          end
        end
        mhf_pkg::MHF_SHIFT: begin
          if (mdc_tick && !mdc_ff) begin
            mdc_ff <= 1'b1;
            if (!mgmt_write_select_ff && bit_cnt_ff >= mhf_pkg::MF_DATA_FIRST) begin
              rd_shift_ff <= {rd_shift_ff[14:0], mdio_sync_ff};
            end
          end else if (mdc_tick) begin
            mdc_ff <= 1'b0;
            if (bit_cnt_ff == mhf_pkg::MF_LAST_BIT) begin
              mdio_out_ff  <= 1'b1;
              mdio_oe_n_ff <= 1'b1;
              state_ff     <= mhf_pkg::MHF_LOAD;
            end else begin
              bit_cnt_ff   <= nxt_bit_cnt;
              tx_shift_ff  <= {tx_shift_ff[62:0], 1'b0};
              mdio_out_ff  <= tx_shift_ff[62];
              // Release the line from turnaround onward on a read
              mdio_oe_n_ff <= !mgmt_write_select_ff
                              && nxt_bit_cnt >= mhf_pkg::MF_TA_FIRST;
            end
          end
        end
        mhf_pkg::MHF_LOAD: state_ff <= mhf_pkg::MHF_FREE;
        mhf_pkg::MHF_FREE: state_ff <= mhf_pkg::MHF_IDLE;
      endcase
    end
  end

  // Hash index from the complemented CRC top bits
  assign da_take    = rx_da_valid && (rx_da_first || da_cnt_ff != 3'h0);
  assign crc_final  = ~crc_raw;
  assign hash_index = crc_final[31:26];
  assign hash_bit   = hash_index[5] ? hash_bits_upper_ff[hash_index[4:0]]
                                    : hash_bits_lower_ff[hash_index[4:0]];

  mhf_crc32 u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (rx_da_first),
    .en      (da_take),
    .data    (rx_da_byte),
    .crc_ff  (crc_raw)
  );

  // Destination address byte counter and multicast bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      da_cnt_ff   <= 3'h0;
      da_mcast_ff <= 1'b0;
      da_eval_ff  <= 1'b0;
    end else begin
      da_eval_ff <= 1'b0;
      if (da_take) begin
        if (rx_da_first) begin
          da_cnt_ff   <= 3'h1;
          da_mcast_ff <= rx_da_byte[0];
        end else if (da_cnt_ff == mhf_pkg::DA_BYTES - 3'h1) begin
          da_cnt_ff  <= 3'h0;
          da_eval_ff <= 1'b1;
        end else begin
          da_cnt_ff <= da_cnt_ff + 3'h1;
        end
      end
    end
  end

  // Verdict one cycle after the sixth byte's CRC settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_valid_ff    <= 1'b0;
      filt_pass_ff     <= 1'b0;
      filt_hash_hit_ff <= 1'b0;
      last_index_ff    <= 6'h00;
    end else begin
      filt_valid_ff <= da_eval_ff;
      if (da_eval_ff) begin
        last_index_ff    <= hash_index;
        filt_hash_hit_ff <= hash_bit;
        if (!da_mcast_ff) begin
          filt_pass_ff <= rx_perfect_match;
        end else if (pass_all_multicast_ff) begin
          filt_pass_ff <= 1'b1;
        end else if (hash_multicast_enable_ff) begin
          filt_pass_ff <= hash_bit;
        end else begin
          filt_pass_ff <= rx_perfect_match;
        end
      end
    end
  end

endmodule : mhf_top

// ---- verif/mhf_props.sv ----
`timescale 1ns/1ps
module mhf_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic filt_valid_ff,
  input wire logic filt_pass_ff,
  input wire logic filt_hash_hit_ff,
  input wire logic mdc_ff,
  input wire logic mdio_out_ff,
  input wire logic mdio_oe_n_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Register access answers in the second access cycle, for one cycle
  property p_rdy; psel && !penable |=> !pready_ff ##1 pready_ff; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not in second access cycle");
  property p_rdy1; pready_ff |=> !pready_ff; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready held too long");
  property p_err; pslverr_ff |-> pready_ff; endproperty
  a_err: assert property (p_err) else $error("error without ready");

  // Filter verdict is a pulse, and results hold between verdicts
  property p_fv; filt_valid_ff |=> !filt_valid_ff; endproperty
  a_fv: assert property (p_fv) else $error("verdict pulse too long");
  property p_hold;
    !filt_valid_ff |-> $stable(filt_pass_ff) && $stable(filt_hash_hit_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("verdict changed without pulse");

  // Management clock halves last at least the shortest divider half
  property p_mh; $rose(mdc_ff) |-> mdc_ff [*8]; endproperty
  a_mh: assert property (p_mh) else $error("clock high half too short");
  property p_ml; $fell(mdc_ff) |-> (!mdc_ff) [*8]; endproperty
  a_ml: assert property (p_ml) else $error("clock low half too short");

  // Data line and its enable only move while the clock is low
  property p_mdio; $changed(mdio_out_ff) |-> !mdc_ff; endproperty
  a_mdio: assert property (p_mdio) else $error("data changed while clock high");
  property p_oe; mdc_ff |-> $stable(mdio_oe_n_ff); endproperty
  a_oe: assert property (p_oe) else $error("enable changed while clock high");

  // Main scenarios
  c_pass: cover property (filt_valid_ff && filt_pass_ff);
  c_err: cover property (pslverr_ff);
  c_mdc: cover property ($rose(mdc_ff));
endmodule : mhf_props

// ---- verif/mhf_phy_model.sv ----
`timescale 1ns/1ps
module mhf_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input  wire logic presetn,
  input  wire logic mdc,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  output logic      mdio_line
);
  logic [15:0] mem [32];
  logic [63:0] sr;
  logic [5:0]  n;
  logic [4:0]  ra;
  logic        rd;
  logic        drv;
  logic        bit_v;

  // Pulled-up line: a released party reads high
  assign mdio_line = (mdio_oe_n | mdio_out) & (~drv | bit_v);

  // Registers start cleared
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 16'h0;
  end

  // Frame of 64 bits sampled on rising clock, answer launched after it
  always @(posedge mdc or negedge presetn) begin
    if (!presetn) begin
      n   <= 6'h0;
      rd  <= 1'b0;
      drv <= 1'b0;
    end else begin
      sr <= {sr[62:0], mdio_line};
      n  <= n + 6'h1;
      if (n == 6'h2E) begin
        ra    <= sr[4:0];
        rd    <= sr[11:10] == 2'h2 && sr[9:5] == PHY_ADDR;
        drv   <= sr[11:10] == 2'h2 && sr[9:5] == PHY_ADDR;
        bit_v <= 1'b0;
      end
      if (rd && n >= 6'h2F && n <= 6'h3E) bit_v <= mem[ra][62 - n];
      if (n == 6'h3F) begin
        rd  <= 1'b0;
        drv <= 1'b0;
        if (sr[28:27] == 2'h1 && sr[26:22] == PHY_ADDR) mem[ra] <= {sr[14:0], mdio_line};
      end
    end
  end
endmodule : mhf_phy_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, er;
  logic [7:0]  paddr, rx_da_byte;
  logic [31:0] pwdata, prdata_ff, rd;
  logic        rx_da_valid, rx_da_first, rx_perfect_match, filt_valid_ff;
  logic        filt_pass_ff, filt_hash_hit_ff, mdc_ff, mdio_line, mdio_out_ff, mdio_oe_n_ff;
  int          num_errors, checks;
  int          half [6] = '{21, 31, 8, 13, 51, 61}; // Dividers 42,62,16,26,102,122 halved

  mhf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
    .pready_ff, .pslverr_ff, .rx_da_valid, .rx_da_first, .rx_da_byte, .rx_perfect_match,
    .filt_valid_ff, .filt_pass_ff, .filt_hash_hit_ff, .mdc_ff, .mdio_in(mdio_line),
    .mdio_out_ff, .mdio_oe_n_ff);
  mhf_phy_model phy (.presetn, .mdc(mdc_ff), .mdio_out(mdio_out_ff),
    .mdio_oe_n(mdio_oe_n_ff), .mdio_line);

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic test_done;
    $display("mismatches %0d of %0d checks", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic lim(input int k, input int m);
    if (k >= m) begin
      num_errors++;
      test_done();
    end
  endtask : lim

  // One APB transfer; answer taken where ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Ready is looked at on the rising edge; the answer is taken at that edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready_ff !== 1'b1 && k < 40);
    lim(k, 40);
    rd = prdata_ff;
    er = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc

  // Hash write, then the settle time before a different value may follow
  task automatic hw(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (400) @(posedge pclk);
  endtask : hw

  task automatic idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h10, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 5000);
    lim(k, 5000);
  endtask : idle

  // Length of one high half of the management clock
  task automatic mhalf(input int e);
    int k;
    k = 0;
    while (mdc_ff !== 1'b1 && k < 500) begin
      @(negedge pclk);
      k++;
    end
    lim(k, 500);
    k = 0;
    while (mdc_ff === 1'b1 && k < 500) begin
      @(negedge pclk);
      k++;
    end
    chk(32'(k), 32'(e));
  endtask : mhalf

  // Six address bytes, then the verdict as {pass, hit}
  task automatic da(input logic [47:0] v, input logic [1:0] e);
    int k;
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      rx_da_valid <= 1'b1;
      rx_da_first <= (i == 0);
      rx_da_byte  <= v[47 - 8 * i -: 8];
    end
    @(posedge pclk);
    rx_da_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (filt_valid_ff !== 1'b1 && k < 20);
    lim(k, 20);
    chk(32'({filt_pass_ff, filt_hash_hit_ff}), 32'(e));
  endtask : da

  function automatic logic [31:0] cmd(input logic [4:0] phy, input logic [4:0] ra,
                                      input logic [3:0] dv, input logic w);
    return {16'h0, phy, ra, dv, w, 1'b1};
  endfunction : cmd

  // Main sequence
  initial begin
    {psel, penable, pwrite, rx_da_valid, rx_da_first, rx_perfect_match} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rx_da_byte = 8'h0;
    num_errors = 0;
    checks = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h08, 32'h0);
    rc(8'h0C, 32'h0);
    rc(8'h10, 32'h0);
    rc(8'h14, 32'h0);
    $display("test reset values done");
    hw(8'h08, 32'hA5A5_F00F);
    hw(8'h0C, 32'h5A5A_0FF0);
    rc(8'h08, 32'hA5A5_F00F);
    rc(8'h0C, 32'h5A5A_0FF0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    $display("test registers done");
    hw(8'h08, 32'h0000_1000);
    hw(8'h0C, 32'h0000_0080);
    apb(1'b1, 8'h00, 32'h4);
    da(48'h1F52_419C_B6AF, 2'h3);
    rc(8'h04, 32'h0000_032C);
    da(48'hA00A_9800_0045, 2'h1);
    rc(8'h04, 32'h0000_0107);
    apb(1'b1, 8'h00, 32'h0);
    da(48'h1F52_419C_B6AF, 2'h1);
    @(posedge pclk) rx_perfect_match <= 1'b1;
    da(48'h1F52_419C_B6AF, 2'h3);
    @(posedge pclk) rx_perfect_match <= 1'b0;
    hw(8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h4);
    da(48'h1F52_419C_B6AF, 2'h0);
    apb(1'b1, 8'h00, 32'h14);
    rc(8'h00, 32'h0000_0014);
    da(48'h1F52_419C_B6AF, 2'h2);
    da(48'hA00A_9800_0045, 2'h1);
    $display("test filter done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h14, 32'hFFFF_C0D0 + i);
      rc(8'h14, 32'h0000_C0D0 + i);
      apb(1'b1, 8'h10, cmd(5'h05, 5'(i), 4'(i), 1'b1));
      mhalf(half[i]);
      rc(8'h10, cmd(5'h05, 5'(i), 4'(i), 1'b1));
      apb(1'b1, 8'h14, 32'h0);
      idle();
      chk(32'(phy.mem[i]), 32'h0000_C0D0 + i);
      rc(8'h14, 32'h0000_C0D0 + i);
      rc(8'h10, cmd(5'h05, 5'(i), 4'(i), 1'b1) - 32'h1);
    end
    apb(1'b1, 8'h10, cmd(5'h05, 5'h03, 4'h2, 1'b0));
    idle();
    rc(8'h14, 32'h0000_C0D3);
    apb(1'b1, 8'h10, cmd(5'h07, 5'h03, 4'h2, 1'b0));
    idle();
    rc(8'h14, 32'h0000_FFFF);
    $display("test management done");
    test_done();
  end
endmodule : testbench

bind mhf_top mhf_props u_props (.pclk, .presetn, .psel, .penable, .pready_ff, .pslverr_ff,
  .filt_valid_ff, .filt_pass_ff, .filt_hash_hit_ff, .mdc_ff, .mdio_out_ff, .mdio_oe_n_ff);
